// ===== csb_consts.svh
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH
// register offsets, bank one, one aligned word each
`define CSB_OFS_INDIRECT 8'h80
`define CSB_OFS_OPTIONS 8'h81
`define CSB_OFS_PCL 8'h82
`define CSB_OFS_STATUS 8'h83
`define CSB_OFS_POINTER 8'h84
`define CSB_OFS_DIR_A 8'h85
`define CSB_OFS_DIR_B 8'h86
`define CSB_OFS_DIR_C 8'h87
`define CSB_OFS_DIR_D 8'h88
`define CSB_OFS_DIR_E 8'h89
`define CSB_OFS_LATCH 8'h8A
`define CSB_OFS_INTCTL 8'h8B
`define CSB_OFS_PIRQ_EN 8'h8C
`define CSB_OFS_RST_CAUSE 8'h8E
`define CSB_OFS_T2_PERIOD 8'h92
`define CSB_OFS_SLAVE_ADDR 8'h93
`define CSB_OFS_SERIAL_STATE 8'h94
// reset values
`define CSB_RST_OPTIONS 8'hFF
`define CSB_RST_DIR_A 6'h3F
`define CSB_RST_DIR_FULL 8'hFF
`define CSB_RST_DIR_E 8'h07
`define CSB_RST_STATUS_POR 8'h18
`define CSB_RST_T2_PERIOD 8'hFF
// field positions
`define CSB_STATUS_TO_BIT 4
`define CSB_STATUS_PD_BIT 3
`define CSB_STATUS_WR_MASK 8'hE7
`define CSB_DIR_E_WR_MASK 8'h17
`define CSB_INTCTL_FLAG0 0
`define CSB_BOR_BIT 0
`define CSB_POR_BIT 1
`endif

// ===== csb_pkg.sv
package csb_pkg;
  // reset class seen by the bank
  typedef enum logic [1:0] {
    CSB_RST_NONE,
    CSB_RST_POWER,
    CSB_RST_EXTERNAL_MASTER_CLEAR,
    CSB_RST_WDT
  } csb_rst_kind_t;
  typedef logic [7:0] csb_byte_t;
  // bus-side transaction state
  typedef enum logic [1:0] {
    CSB_BUS_IDLE,
    CSB_BUS_WRESP,
    CSB_BUS_RRESP
  } csb_bus_state_t;
endpackage : csb_pkg

// ===== csb_reg_if.sv
`timescale 1ns/100ps
// register access path between bus slave and register bank
interface csb_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  modport slave(input wr_en, input wr_addr, input wr_data, input rd_addr,
    output rd_data, output rd_hit);
  modport master(output wr_en, output wr_addr, output wr_data, output rd_addr,
    input rd_data, input rd_hit);
endinterface : csb_reg_if

// ===== csb_sync2.sv
`timescale 1ns/100ps
// two-stage synchroniser for pin levels
module csb_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : csb_sync2

// ===== csb_axil_slave.sv
`timescale 1ns/100ps
// axi4-lite slave, one write and one read at a time
module csb_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  csb_reg_if.master regs
);
  import csb_pkg::*;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_q;
  logic [7:0] wd_q;
  logic wstrb0_q;
  logic aw_take, w_take, ar_take, do_write;
  // capture address and data in either order
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign regs.wr_en = do_write && wstrb0_q;
  assign regs.wr_addr = aw_q;
  assign regs.wr_data = wd_q;
  assign regs.rd_addr = s_axi_araddr[9:2];
  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // read channel, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, regs.rd_data};
        s_axi_rresp <= 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : csb_axil_slave

// ===== csb_core_sfr_bank.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "csb_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - indirect, counter low, status, pointer, latch and interrupt control answer identically at their upper and lower bank offsets.
// - program counter upper bits have no address; only the five-bit latch reaches them.
// - on each counter load the latch is copied into counter bits 12 to 8.
// - power-up and brown-out resets load one value set, clear and watchdog resets another.
// - the port d direction register resets to all ones on every reset.
//////////////////////////////////////////////////////////////////////////////
module csb_core_sfr_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_reset_n,
  input wire logic external_master_clear_n,
  input wire logic watchdog_reset,
  input wire logic brown_out_flag_n,
  input wire logic counter_load,
  input wire logic [7:0] indirect_data_in,
  input wire logic [2:0] status_alu_flags,
  input wire logic [7:0] serial_state_in,
  input wire logic [2:0] slave_port_flags,
  output logic [12:0] program_counter,
  output logic [7:0] indirect_pointer,
  output logic indirect_wr,
  output logic [7:0] indirect_wr_data,
  output logic [7:0] options_out,
  output logic [7:0] processor_status,
  output logic [5:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic [7:0] port_d_direction,
  output logic [7:0] port_e_direction,
  output logic [7:0] interrupt_control,
  output logic [7:0] peripheral_irq_enable,
  output logic [7:0] timer2_period,
  output logic [7:0] serial_slave_address
);
  import csb_pkg::*;
  csb_reg_if regs ();
  csb_rst_kind_t rst_kind;
  logic por_s, external_master_clear_s, wdt_s, bor_s;
  logic [12:0] pc_q;
  logic [4:0] latch_q;
  logic [7:0] status_q, ptr_q, opt_q, dira_q, dirb_q, dirc_q, dird_q, dire_q;
  logic [7:0] intctl_q, pie_q, t2p_q, sadr_q;
  logic [1:0] cause_q;
  logic ind_wr_q;
  logic [7:0] ind_wd_q;
  logic any_reset, power_reset;
  logic [7:0] wa, ra;
  logic [7:0] rd_mux;
  logic hit;
  ////////////////////////////////////////////////////////////////////////////
  // pin-level reset sources made active high, so a cleared synchroniser reads idle
  csb_sync2 #(.WIDTH(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({~power_reset_n, ~external_master_clear_n, watchdog_reset, ~brown_out_flag_n}),
    .sync_out({por_s, external_master_clear_s, wdt_s, bor_s})
  );
  csb_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs.master)
  );
  ////////////////////////////////////////////////////////////////////////////
  // reset classification, power-up and brown-out win over clear and watchdog
  assign rst_kind = (por_s || bor_s) ? CSB_RST_POWER :
                    external_master_clear_s ? CSB_RST_EXTERNAL_MASTER_CLEAR :
                    wdt_s ? CSB_RST_WDT : CSB_RST_NONE;
  assign any_reset = (rst_kind != CSB_RST_NONE);
  assign power_reset = (rst_kind == CSB_RST_POWER);
  // offsets 00, 02 to 04, 0A and 0B mirror across banks: bit 7 of the offset ignored
  assign wa = (regs.wr_addr[6:0] <= 7'h04 && regs.wr_addr[6:0] != 7'h01 ||
               regs.wr_addr[6:0] == 7'h0A ||
               regs.wr_addr[6:0] == 7'h0B) ? {1'b1, regs.wr_addr[6:0]} : regs.wr_addr;
  assign ra = (regs.rd_addr[6:0] <= 7'h04 && regs.rd_addr[6:0] != 7'h01 ||
               regs.rd_addr[6:0] == 7'h0A ||
               regs.rd_addr[6:0] == 7'h0B) ? {1'b1, regs.rd_addr[6:0]} : regs.rd_addr;
  wire we_ind = regs.wr_en && wa == `CSB_OFS_INDIRECT;
  wire we_opt = regs.wr_en && wa == `CSB_OFS_OPTIONS;
  wire we_pcl = regs.wr_en && wa == `CSB_OFS_PCL;
  wire we_sta = regs.wr_en && wa == `CSB_OFS_STATUS;
  wire we_ptr = regs.wr_en && wa == `CSB_OFS_POINTER;
  wire we_dra = regs.wr_en && wa == `CSB_OFS_DIR_A;
  wire we_drb = regs.wr_en && wa == `CSB_OFS_DIR_B;
  wire we_drc = regs.wr_en && wa == `CSB_OFS_DIR_C;
  wire we_drd = regs.wr_en && wa == `CSB_OFS_DIR_D;
  wire we_dre = regs.wr_en && wa == `CSB_OFS_DIR_E;
  wire we_lat = regs.wr_en && wa == `CSB_OFS_LATCH;
  wire we_int = regs.wr_en && wa == `CSB_OFS_INTCTL;
  wire we_pie = regs.wr_en && wa == `CSB_OFS_PIRQ_EN;
  wire we_rc = regs.wr_en && wa == `CSB_OFS_RST_CAUSE;
  wire we_t2p = regs.wr_en && wa == `CSB_OFS_T2_PERIOD;
  wire we_sad = regs.wr_en && wa == `CSB_OFS_SLAVE_ADDR;
  ////////////////////////////////////////////////////////////////////////////
  // read selection; upper counter bits have no offset
  always_comb begin
    rd_mux = 8'h00;
    hit = 1'b1;
    case (ra)
      `CSB_OFS_INDIRECT: rd_mux = indirect_data_in;
      `CSB_OFS_OPTIONS: rd_mux = opt_q;
      `CSB_OFS_PCL: rd_mux = pc_q[7:0];
      `CSB_OFS_STATUS: rd_mux = status_q;
      `CSB_OFS_POINTER: rd_mux = ptr_q;
      `CSB_OFS_DIR_A: rd_mux = {2'h0, dira_q[5:0]};
      `CSB_OFS_DIR_B: rd_mux = dirb_q;
      `CSB_OFS_DIR_C: rd_mux = dirc_q;
      `CSB_OFS_DIR_D: rd_mux = dird_q;
      `CSB_OFS_DIR_E: rd_mux = dire_q;
      `CSB_OFS_LATCH: rd_mux = {3'h0, latch_q};
      `CSB_OFS_INTCTL: rd_mux = intctl_q;
      `CSB_OFS_PIRQ_EN: rd_mux = pie_q;
      `CSB_OFS_RST_CAUSE: rd_mux = {6'h00, cause_q};
      `CSB_OFS_T2_PERIOD: rd_mux = t2p_q;
      `CSB_OFS_SLAVE_ADDR: rd_mux = sadr_q;
      `CSB_OFS_SERIAL_STATE: rd_mux = {2'h0, serial_state_in[5:0]};
      default: begin
        rd_mux = 8'h00;
        hit = 1'b0;
      end
    endcase
  end
  assign regs.rd_data = rd_mux;
  assign regs.rd_hit = hit;
  ////////////////////////////////////////////////////////////////////////////
  // program counter and latch
  always_ff @(posedge aclk) begin
    if (!aresetn || any_reset) begin
      pc_q <= 13'h0000;
      latch_q <= 5'h00;
    end else begin
      if (we_lat) latch_q <= regs.wr_data[4:0];
      if (we_pcl) pc_q <= {latch_q, regs.wr_data};
      else if (counter_load) pc_q <= {latch_q, pc_q[7:0]};
    end
  end
  // status: power value on power-up or brown-out, timeout/powerdown kept on clear and watchdog resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `CSB_RST_STATUS_POR;
    end else if (power_reset) begin
      status_q <= `CSB_RST_STATUS_POR;
    end else if (any_reset) begin
      status_q <= {3'h0, status_q[`CSB_STATUS_TO_BIT], status_q[`CSB_STATUS_PD_BIT],
                   status_q[2:0]};
    end else if (we_sta) begin
      status_q <= (regs.wr_data & `CSB_STATUS_WR_MASK) |
                  (status_q & ~`CSB_STATUS_WR_MASK);
    end else begin
      status_q <= {status_q[7:3], status_alu_flags};
    end
  end
  // plain configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn || any_reset) begin
      opt_q <= `CSB_RST_OPTIONS;
      dira_q <= {2'h0, `CSB_RST_DIR_A};
      dirb_q <= `CSB_RST_DIR_FULL;
      dirc_q <= `CSB_RST_DIR_FULL;
      dird_q <= `CSB_RST_DIR_FULL;
      dire_q <= `CSB_RST_DIR_E;
      pie_q <= 8'h00;
      t2p_q <= `CSB_RST_T2_PERIOD;
      sadr_q <= 8'h00;
    end else begin
      if (we_opt) opt_q <= regs.wr_data;
      if (we_dra) dira_q <= {2'h0, regs.wr_data[5:0]};
      if (we_drb) dirb_q <= regs.wr_data;
      if (we_drc) dirc_q <= regs.wr_data;
      if (we_drd) dird_q <= regs.wr_data;
      dire_q <= we_dre ? {slave_port_flags, regs.wr_data[4], 1'b0, regs.wr_data[2:0]} :
                {slave_port_flags, dire_q[4:0]};
      if (we_pie) pie_q <= regs.wr_data;
      if (we_t2p) t2p_q <= regs.wr_data;
      if (we_sad) sadr_q <= regs.wr_data;
    end
  end
  // pointer keeps value on every reset except aresetn, which clears it; interrupt control keeps only bit 0 on non-power resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= 8'h00;
      intctl_q <= 8'h00;
    end else if (any_reset) begin
      intctl_q <= {7'h00, power_reset ? 1'b0 : intctl_q[`CSB_INTCTL_FLAG0]};
    end else begin
      if (we_ptr) ptr_q <= regs.wr_data;
      if (we_int) intctl_q <= regs.wr_data;
    end
  end
  // reset cause flags: power-up clears its flag, brown-out clears its own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= 2'h0;
    end else if (power_reset) begin
      cause_q <= {cause_q[`CSB_POR_BIT] & !por_s, !bor_s};
    end else if (we_rc) begin
      cause_q <= regs.wr_data[1:0];
    end
  end
  // indirect access forwards to data memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_wr_q <= 1'b0;
      ind_wd_q <= 8'h00;
    end else begin
      ind_wr_q <= we_ind;
      if (we_ind) ind_wd_q <= regs.wr_data;
    end
  end
  assign program_counter = pc_q;
  assign indirect_pointer = ptr_q;
  assign indirect_wr = ind_wr_q;
  assign indirect_wr_data = ind_wd_q;
  assign options_out = opt_q;
  assign processor_status = status_q;
  assign port_a_direction = dira_q[5:0];
  assign port_b_direction = dirb_q;
  assign port_c_direction = dirc_q;
  assign port_d_direction = dird_q;
  assign port_e_direction = dire_q;
  assign interrupt_control = intctl_q;
  assign peripheral_irq_enable = pie_q;
  assign timer2_period = t2p_q;
  assign serial_slave_address = sadr_q;
endmodule : csb_core_sfr_bank

// ===== csb_bank_asserts.sv
`timescale 1ns/100ps
module csb_bank_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic power_reset_n,
  input wire logic external_master_clear_n,
  input wire logic watchdog_reset,
  input wire logic brown_out_flag_n,
  input wire logic counter_load,
  input wire logic [12:0] program_counter,
  input wire logic [7:0] options_out,
  input wire logic [7:0] processor_status,
  input wire logic [7:0] port_d_direction,
  input wire logic [7:0] timer2_period
);
  logic [7:0] aw_q;
  logic [4:0] wd_q;
  logic strb_q;
  logic [4:0] latch_q;
  logic evt_q;
  logic evt2_q;
  logic any_rst;
  logic [7:0] ar_idx;
  logic ar_unmapped;
  logic latch_hit;
  //////////////////////////////////////////////////////////////////////////////
  // address decode of what is watched
  assign any_rst = !power_reset_n || !external_master_clear_n || watchdog_reset ||
    !brown_out_flag_n;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_unmapped = ar_idx == 8'h8D || ar_idx == 8'h8F || ar_idx == 8'h90 ||
    ar_idx == 8'h91 || (ar_idx >= 8'h95 && ar_idx <= 8'h9F);
  assign latch_hit = (aw_q == 8'h8A || aw_q == 8'h0A) && strb_q;
  // capture of the write in flight
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr[9:2];
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[4:0];
    if (s_axi_wvalid && s_axi_wready) strb_q <= s_axi_wstrb[0];
  end
  // shadow of the upper counter latch
  always_ff @(posedge aclk) begin
    if (!aresetn || any_rst) latch_q <= 5'h00;
    else if (s_axi_bvalid && s_axi_bready && latch_hit) latch_q <= wd_q;
  end
  // recent causes that may move the counter's upper bits
  always_ff @(posedge aclk) begin
    evt_q <= counter_load || s_axi_bvalid || (s_axi_awvalid && s_axi_awready) || any_rst;
    evt2_q <= evt_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  unmapped_read_zero_a: assert property (
    s_axi_arvalid && s_axi_arready && ar_unmapped |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("unmapped read not zero");
  write_resp_okay_a: assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("write response not okay");
  upper_load_a: assert property (
    counter_load && s_axi_awready && !s_axi_bvalid |=> program_counter[12:8] == $past(latch_q))
    else $error("counter upper bits not loaded from latch");
  upper_hold_a: assert property (
    $changed(program_counter[12:8]) |-> evt_q || evt2_q)
    else $error("counter upper bits moved without a load");
  dir_d_reset_a: assert property (
    any_rst [*4] |-> port_d_direction == 8'hFF) else $error("port d direction not all ones");
  power_column_a: assert property (
    !power_reset_n [*4] |-> processor_status[4:3] == 2'h3 && options_out == 8'hFF &&
    timer2_period == 8'hFF) else $error("power reset values wrong");
  other_column_a: assert property (
    $fell(external_master_clear_n) && power_reset_n |-> ##4
    processor_status[4:3] == $past(processor_status[4:3], 4) && options_out == 8'hFF)
    else $error("clear reset values wrong");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  // main scenarios reached
  cover property (counter_load);
  cover property ($fell(external_master_clear_n));
  cover property (watchdog_reset [*4]);
endmodule : csb_bank_asserts

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic power_reset_n, external_master_clear_n, watchdog_reset, brown_out_flag_n;
  logic counter_load;
  logic [7:0] indirect_data_in, port_d_direction;
  logic [12:0] program_counter;
  int mismatches = 0;
  int tests_run = 0;
  // reset table and access table
  logic [7:0] r_idx [13] = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A,
    8'h8C, 8'h92, 8'h93, 8'h94};
  logic [7:0] r_val [13] = '{8'hFF, 8'h00, 8'h18, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00};
  logic [7:0] t_w [16] = '{8'h81, 8'h84, 8'h04, 8'h0A, 8'h8A, 8'h8B, 8'h0B, 8'h8C, 8'h03,
    8'h86, 8'h87, 8'h88, 8'h92, 8'h93, 8'h8E, 8'h85};
  logic [7:0] t_r [16] = '{8'h81, 8'h04, 8'h84, 8'h8A, 8'h0A, 8'h0B, 8'h8B, 8'h8C, 8'h83,
    8'h86, 8'h87, 8'h88, 8'h92, 8'h93, 8'h8E, 8'h85};
  logic [7:0] t_keep [16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'h20,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'hFF};
  logic [7:0] t_set [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  //////////////////////////////////////////////////////////////////////////////
  csb_core_sfr_bank i_csb_core_sfr_bank (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_reset_n,
    .external_master_clear_n, .watchdog_reset, .brown_out_flag_n, .counter_load,
    .indirect_data_in, .status_alu_flags(3'h0), .serial_state_in(8'h00),
    .slave_port_flags(3'h0), .program_counter, .indirect_pointer(), .indirect_wr(),
    .indirect_wr_data(), .options_out(), .processor_status(), .port_a_direction(),
    .port_b_direction(), .port_c_direction(), .port_d_direction, .port_e_direction(),
    .interrupt_control(), .peripheral_irq_enable(), .timer2_period(),
    .serial_slave_address());
  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] expect_rd(input logic [7:0] idx, input logic [7:0] wd);
    case (idx)
      8'h83, 8'h03: expect_rd = wd | 8'h18;
      8'h8E: expect_rd = wd & 8'h03;
      8'h85: expect_rd = wd & 8'h3F;
      8'h8A, 8'h0A: expect_rd = wd & 8'h1F;
      default: expect_rd = wd;
    endcase
  endfunction : expect_rd
  function automatic logic unmapped(input logic [7:0] idx);
    unmapped = idx == 8'h8D || idx == 8'h8F || idx == 8'h90 || idx == 8'h91 || idx >= 8'h95;
  endfunction : unmapped
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one write, address and data offered together
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] data, input logic [3:0] strb);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, data};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check($sformatf("reg %h", idx), exp, s_axi_rdata[7:0]);
  endtask : rd_check
  // hold one reset source, or power-up with brown-out for kind 0, for six cycles
  task automatic pulse_reset(input int kind);
    @(posedge aclk);
    if (kind == 0) power_reset_n <= 1'b0;
    if (kind == 0 || kind == 3) brown_out_flag_n <= 1'b0;
    if (kind == 1) external_master_clear_n <= 1'b0;
    if (kind == 2) watchdog_reset <= 1'b1;
    repeat (6) @(posedge aclk);
    power_reset_n <= 1'b1;
    brown_out_flag_n <= 1'b1;
    external_master_clear_n <= 1'b1;
    watchdog_reset <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse_reset
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #(5000 * 50);
    mismatches++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    logic [7:0] v;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {power_reset_n, external_master_clear_n, brown_out_flag_n} = 3'h7;
    {watchdog_reset, counter_load, indirect_data_in} = '0;
    void'($urandom(94170));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 13; i++) rd_check(r_idx[i], r_val[i]);
    check("port d dir", 8'hFF, port_d_direction);
    for (int i = 8'h8D; i <= 8'h9F; i++) begin
      if (unmapped(i[7:0])) axi_write(i[7:0], 8'($urandom), 4'hF);
      if (unmapped(i[7:0])) rd_check(i[7:0], 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      v = (8'($urandom) & t_keep[i]) | t_set[i];
      axi_write(t_w[i], v, 4'hF);
      rd_check(t_r[i], expect_rd(t_r[i], v));
    end
    v = 8'($urandom);
    indirect_data_in <= v;
    rd_check(8'h80, v);
    rd_check(8'h00, v);
    axi_write(8'h86, 8'hA5, 4'hF);
    axi_write(8'h86, 8'h5A, 4'hE);
    rd_check(8'h86, 8'hA5);
    v = 8'($urandom) & 8'h1F;
    axi_write(8'h8A, v, 4'hF);
    counter_load <= 1'b1;
    @(posedge aclk) counter_load <= 1'b0;
    repeat (2) @(posedge aclk);
    check("pc upper", v, {3'h0, program_counter[12:8]});
    axi_write(8'h0A, ~v, 4'hF);
    repeat (3) @(posedge aclk);
    check("pc upper held", v, {3'h0, program_counter[12:8]});
    axi_write(8'h82, 8'h3C, 4'hF);
    repeat (3) @(posedge aclk);
    check("pc after low write", ~v & 8'h1F, {3'h0, program_counter[12:8]});
    check("pc low", 8'h3C, program_counter[7:0]);
    for (int k = 0; k < 4; k++) begin
      axi_write(8'h88, 8'h00, 4'hF);
      axi_write(8'h81, 8'h00, 4'hF);
      axi_write(8'h83, 8'h20, 4'hF);
      axi_write(8'h8E, 8'h03, 4'hF);
      pulse_reset(k);
      check("port d dir", 8'hFF, port_d_direction);
      rd_check(8'h88, 8'hFF);
      rd_check(8'h81, 8'hFF);
      rd_check(8'h83, 8'h18);
      rd_check(8'h8E, (k == 0) ? 8'h00 : (k == 3) ? 8'h02 : 8'h03);
    end
    tally_and_finish();
  end
endmodule : tb_top

bind csb_core_sfr_bank csb_bank_asserts i_csb_bank_asserts (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .power_reset_n, .external_master_clear_n, .watchdog_reset,
  .brown_out_flag_n,
  .counter_load, .program_counter, .options_out, .processor_status, .port_d_direction,
  .timer2_period);
